// >>> ocram_axi_host.sv
// axi4 manager model that issues single-beat writes and reads into the block
`timescale 1ns/1ns
module ocram_axi_host import ocram_pkg::*;
(
  // clock
  input  wire logic              clk,
  // request side driven by the manager
  output logic [ID_W-1:0]        awid, arid,
  output logic [AXI_AW-1:0]      awaddr, araddr,
  output logic [7:0]             awlen, arlen,
  output logic [2:0]             awsize, arsize,
  output logic [1:0]             awburst, arburst,
  output logic                   awvalid, arvalid, wlast, wvalid, bready, rready,
  output logic [DATA_W-1:0]      wdata,
  output logic [BYTES-1:0]       wstrb,
  // answers from the block
  input  wire logic              awready, wready, bvalid, arready, rlast, rvalid,
  input  wire logic [ID_W-1:0]   bid, rid,
  input  wire logic [1:0]        bresp, rresp,
  input  wire logic [DATA_W-1:0] rdata
);
  // one id only, strictly in order; read beats always taken
  initial
  begin
    awid = 4'h3;
    arid = 4'h3;
    {awlen, arlen, awaddr, araddr, wdata} = '0;
    {awsize, arsize} = 6'h12;
    {awburst, arburst} = {BURST_INCR, BURST_INCR};
    {awvalid, arvalid, wvalid, bready} = '0;
    {wlast, rready} = 2'h3;
    wstrb = 4'hf;
  end
  // single aligned beat, so a burst never spans a 4 kB page
  task automatic write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    awvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wdata <= d;
    wvalid <= 1'b1;
    do @(posedge clk); while (wready !== 1'b1);
    wvalid <= 1'b0;
    wdata <= ~d;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // single aligned read beat; rready stays high, so data is taken with rvalid
  task automatic read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
endmodule

// >>> ocram_pkg.sv
// constants and types for the on-chip ram or rom block
// Behaviour
// - collision read follows selected mode
// - read data no sooner than one cycle
// - level one register adds one cycle
// - level two register adds another cycle
// - reset request gates memory clock off
// - ecc option only widens stored word
// - incrementing bursts up to 256 beats
// - wrapping bursts of 2, 4, 8, 16
// - narrow unaligned writes touch selected lanes
// - axi data width 32 bits
// - axi address width 32 bits
// - single clock for agents and memory
// - rom mode ends writes without effect; debug editor writes still take effect
// - idle gating enables clock only when active
// - independent channels, two agents share storage
// - memory is writable or read-only
// - contents loaded from chosen image at start
// - debug editor port reads and writes storage
// - byte enables gate writes, reads full
// - agent address is word address
package ocram_pkg;
  localparam int DATA_W  = 32;
  localparam int ECC_W   = 8;
  localparam int MEM_W   = DATA_W + ECC_W;
  localparam int BYTES   = DATA_W / 8;
  localparam int LANE_W  = 2;
  localparam int DEPTH   = 256;
  localparam int WADDR_W = 8;
  localparam int AXI_AW  = 32;
  localparam int ID_W    = 4;
  localparam int APB_AW  = 12;
  localparam logic [APB_AW-1:0] REG_CTRL   = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam int CTRL_COLL = 0;
  localparam int CTRL_L1   = 2;
  localparam int CTRL_L2   = 3;
  localparam int CTRL_GATE = 4;
  localparam int CTRL_ROM  = 5;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_003F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int ST_INIT  = 0;
  localparam int ST_GATE  = 1;
  localparam int ST_WBUSY = 2;
  localparam int ST_RBUSY = 3;
  localparam int ST_RREQ  = 4;
  localparam bit INIT_ENABLE = 1'b1;
  localparam bit INIT_USER   = 1'b0;
  localparam bit EDITOR_EN   = 1'b1;
  localparam logic [MEM_W-1:0] DEFAULT_IMAGE_WORD = 40'h00_0000_0000;
  localparam logic [MEM_W-1:0] USER_IMAGE_SEED    = 40'hA5_5A5A_0000;
  localparam logic [MEM_W-1:0] UNDEF_WORD         = 40'hFF_FFFF_FFFF;
  localparam logic [WADDR_W-1:0] INIT_LAST = 8'hFF;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [1:0] BURST_RSVD = 2'h3;
  localparam logic [2:0] MAX_SIZE   = 3'h2;
  localparam logic [7:0] WRAP_L2    = 8'h01;
  localparam logic [7:0] WRAP_L4    = 8'h03;
  localparam logic [7:0] WRAP_L8    = 8'h07;
  localparam logic [7:0] WRAP_L16   = 8'h0F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {collision_undefined, collision_prior_value,
                            collision_new_value} ocram_coll_type;
  typedef enum {W_IDLE, W_DATA, W_RESP} ocram_wstate_type;
  typedef enum {R_IDLE, R_READ, R_DATA} ocram_rstate_type;
endpackage

// >>> ocram_top.sv
// on-chip ram or rom with memory-mapped, axi4, debug and apb control ports
`timescale 1ns/1ns
module ocram_top
(
  // clock, reset and memory protection
  input  wire logic                            clk,
  input  wire logic                            srst,
  input  wire logic                            reset_req,
  output logic                                 memory_clock_gate,
  // memory-mapped agent
  input  wire logic [ocram_pkg::WADDR_W-1:0]   mm_address,
  input  wire logic                            mm_read,
  input  wire logic                            mm_write,
  input  wire logic [ocram_pkg::BYTES-1:0]     mm_byteenable,
  input  wire logic [ocram_pkg::MEM_W-1:0]     mm_writedata,
  output logic      [ocram_pkg::MEM_W-1:0]     mm_readdata,
  output logic                                 mm_readdatavalid,
  output logic                                 mm_waitrequest,
  // axi4 write channels
  input  wire logic [ocram_pkg::ID_W-1:0]      awid,
  input  wire logic [ocram_pkg::AXI_AW-1:0]    awaddr,
  input  wire logic [7:0]                      awlen,
  input  wire logic [2:0]                      awsize,
  input  wire logic [1:0]                      awburst,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [ocram_pkg::DATA_W-1:0]    wdata,
  input  wire logic [ocram_pkg::BYTES-1:0]     wstrb,
  input  wire logic                            wlast,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic      [ocram_pkg::ID_W-1:0]      bid,
  output logic      [1:0]                      bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  // axi4 read channels
  input  wire logic [ocram_pkg::ID_W-1:0]      arid,
  input  wire logic [ocram_pkg::AXI_AW-1:0]    araddr,
  input  wire logic [7:0]                      arlen,
  input  wire logic [2:0]                      arsize,
  input  wire logic [1:0]                      arburst,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic      [ocram_pkg::ID_W-1:0]      rid,
  output logic      [ocram_pkg::DATA_W-1:0]    rdata,
  output logic      [1:0]                      rresp,
  output logic                                 rlast,
  output logic                                 rvalid,
  input  wire logic                            rready,
  // debug content editor port
  input  wire logic                            dbg_req,
  input  wire logic                            dbg_write,
  input  wire logic [ocram_pkg::WADDR_W-1:0]   dbg_addr,
  input  wire logic [ocram_pkg::MEM_W-1:0]     dbg_wdata,
  output logic      [ocram_pkg::MEM_W-1:0]     dbg_rdata,
  output logic                                 dbg_rvalid,
  // apb control port
  input  wire logic [ocram_pkg::APB_AW-1:0]    paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr
);
  import ocram_pkg::*;

  logic [MEM_W-1:0]   mem [DEPTH];
  logic [31:0]        ctrl_reg;
  logic [31:0]        status;
  logic               init_busy_reg;
  logic [WADDR_W-1:0] init_addr_reg;
  logic [2:0]         rv_pipe_reg;
  logic [MEM_W-1:0]   rd_pipe_reg [3];
  ocram_wstate_type   ws_reg;
  ocram_rstate_type   rs_reg;
  logic [ID_W-1:0]    w_id_reg;
  logic [ID_W-1:0]    r_id_reg;
  logic [AXI_AW-1:0]  w_addr_reg;
  logic [AXI_AW-1:0]  r_addr_reg;
  logic [7:0]         w_len_reg;
  logic [7:0]         r_len_reg;
  logic [7:0]         r_cnt_reg;
  logic [2:0]         w_size_reg;
  logic [2:0]         r_size_reg;
  logic [1:0]         w_burst_reg;
  logic [1:0]         r_burst_reg;
  logic               w_err_reg;
  logic               r_err_reg;
  logic [DATA_W-1:0]  rdata_reg;
  ocram_coll_type     coll;
  logic               ctrl_l1;
  logic               ctrl_l2;
  logic               ctrl_gate;
  logic               ctrl_rom;
  logic [1:0]         lat;
  logic               blocked;
  logic               mm_rd_do;
  logic               mm_wr_do;
  logic               w_hs;
  logic               axi_wr_do;
  logic               axi_rd_go;
  logic               axi_rd_do;
  logic               dbg_do;
  logic               activity;
  logic               apb_wr;
  logic               apb_hit;
  logic [WADDR_W-1:0] axi_wa;
  logic [WADDR_W-1:0] axi_ra;
  logic [MEM_W-1:0]   mm_old;
  logic [MEM_W-1:0]   axi_old;
  logic [MEM_W-1:0]   mm_new;
  logic [MEM_W-1:0]   axi_new;
  logic [MEM_W-1:0]   axi_rd_word;

  // next beat address for fixed, incrementing and wrapping bursts
  function automatic logic [AXI_AW-1:0] next_addr(input logic [AXI_AW-1:0] a,
    input logic [2:0] sz, input logic [7:0] ln, input logic [1:0] bt);
    logic [AXI_AW-1:0] step;
    logic [AXI_AW-1:0] inc;
    logic [AXI_AW-1:0] span;
    step = AXI_AW'(1) << sz;
    inc  = (a & ~(step - AXI_AW'(1))) + step;
    span = step * (AXI_AW'(ln) + AXI_AW'(1));
    if (bt == BURST_WRAP)
      next_addr = (a & ~(span - AXI_AW'(1))) | (inc & (span - AXI_AW'(1)));
    else if (bt == BURST_INCR)
      next_addr = inc;
    else
      next_addr = a;
  endfunction

  // byte lanes that a narrow or unaligned beat may touch
  function automatic logic [BYTES-1:0] lane_mask(input logic [1:0] lo, input logic [2:0] sz);
    lane_mask = '0;
    for (int i = 0; i < BYTES; i++)
      lane_mask[i] = (2'(i) >= lo) && ((2'(i) >> sz) == (lo >> sz));
  endfunction

  // burst forms that are refused with an error response
  function automatic logic burst_err(input logic [1:0] bt, input logic [7:0] ln,
    input logic [2:0] sz);
    logic wrap_ok;
    wrap_ok = (ln == WRAP_L2) || (ln == WRAP_L4) || (ln == WRAP_L8) || (ln == WRAP_L16);
    burst_err = (sz > MAX_SIZE) || (bt == BURST_RSVD) || ((bt == BURST_WRAP) && !wrap_ok);
  endfunction

  // byte-lane merge; ecc bits are only stored, never computed
  function automatic logic [MEM_W-1:0] merge(input logic [MEM_W-1:0] old_w,
    input logic [MEM_W-1:0] new_w, input logic [BYTES-1:0] be, input logic ecc_we);
    merge = old_w;
    for (int i = 0; i < BYTES; i++)
      if (be[i])
        merge[i*8 +: 8] = new_w[i*8 +: 8];
    if (ecc_we)
      merge[MEM_W-1:DATA_W] = new_w[MEM_W-1:DATA_W];
  endfunction

  // read data when a write hits the same word in the same cycle
  function automatic logic [MEM_W-1:0] coll_pick(input ocram_coll_type m, input logic hit,
    input logic [MEM_W-1:0] old_w, input logic [MEM_W-1:0] new_w);
    coll_pick = old_w;
    if (hit)
      case (m)
        collision_prior_value: coll_pick = old_w;
        collision_new_value:   coll_pick = new_w;
        default:               coll_pick = UNDEF_WORD;
      endcase
  endfunction

  // control fields
  assign coll      = ocram_coll_type'(ctrl_reg[CTRL_COLL +: 2]);
  assign ctrl_l1   = ctrl_reg[CTRL_L1];
  assign ctrl_l2   = ctrl_reg[CTRL_L2];
  assign ctrl_gate = ctrl_reg[CTRL_GATE];
  assign ctrl_rom  = ctrl_reg[CTRL_ROM];
  assign lat       = 2'(ctrl_l1) + 2'(ctrl_l2);

  // access qualifiers; all agents share one clock and one array
  assign blocked   = reset_req | init_busy_reg;
  assign mm_rd_do  = mm_read & ~blocked;
  assign mm_wr_do  = mm_write & ~blocked & ~ctrl_rom;
  assign w_hs      = (ws_reg == W_DATA) & wvalid & wready;
  assign axi_wr_do = w_hs & ~w_err_reg & ~ctrl_rom;
  assign axi_rd_go = (rs_reg == R_READ) & ~blocked;
  assign axi_rd_do = axi_rd_go & ~r_err_reg;
  assign dbg_do    = EDITOR_EN & dbg_req & ~blocked;
  assign activity  = mm_rd_do | mm_wr_do | axi_wr_do | axi_rd_do | dbg_do | init_busy_reg;
  assign memory_clock_gate = ~reset_req & (activity | ~ctrl_gate);

  // word addresses and merged write words
  assign axi_wa      = w_addr_reg[WADDR_W+LANE_W-1:LANE_W];
  assign axi_ra      = r_addr_reg[WADDR_W+LANE_W-1:LANE_W];
  assign mm_old      = mem[mm_address];
  assign axi_old     = mem[axi_wa];
  assign mm_new      = merge(mm_old, mm_writedata, mm_byteenable, |mm_byteenable);
  assign axi_new     = merge(axi_old, {{ECC_W{1'b0}}, wdata},
                             wstrb & lane_mask(w_addr_reg[1:0], w_size_reg), 1'b0);
  assign axi_rd_word = coll_pick(coll, mm_wr_do && (mm_address == axi_ra),
                                 mem[axi_ra], mm_new);

  // array writes, only while the memory clock is enabled
  always_ff @(posedge clk)
  begin
    if (memory_clock_gate)
    begin
      if (init_busy_reg)
        mem[init_addr_reg] <= INIT_USER ? (USER_IMAGE_SEED ^ MEM_W'(init_addr_reg))
                                        : DEFAULT_IMAGE_WORD;
      if (axi_wr_do)
        mem[axi_wa] <= axi_new;
      if (mm_wr_do)
        mem[mm_address] <= mm_new;
      if (dbg_do && dbg_write)
        mem[dbg_addr] <= dbg_wdata;
    end
  end

  // content load walk after reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      init_busy_reg <= INIT_ENABLE;
      init_addr_reg <= '0;
    end
    else if (init_busy_reg && !reset_req)
    begin
      init_addr_reg <= init_addr_reg + WADDR_W'(1);
      if (init_addr_reg == INIT_LAST)
        init_busy_reg <= 1'b0;
    end
  end

  // memory-mapped read pipeline: array stage, then optional l1 and l2
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rv_pipe_reg    <= '0;
      rd_pipe_reg[0] <= '0;
      rd_pipe_reg[1] <= '0;
      rd_pipe_reg[2] <= '0;
    end
    else
    begin
      rv_pipe_reg <= {rv_pipe_reg[1:0], mm_rd_do};
      if (mm_rd_do)
        rd_pipe_reg[0] <= coll_pick(coll, axi_wr_do && (axi_wa == mm_address),
                                    mm_old, axi_new);
      rd_pipe_reg[1] <= rd_pipe_reg[0];
      rd_pipe_reg[2] <= rd_pipe_reg[1];
    end
  end

  // output tap chosen by the number of enabled register levels
  assign mm_readdata      = rd_pipe_reg[lat];
  assign mm_readdatavalid = rv_pipe_reg[lat];
  assign mm_waitrequest   = blocked;

  // axi write channel: address, beats, response, strictly in order
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ws_reg      <= W_IDLE;
      w_id_reg    <= '0;
      w_addr_reg  <= '0;
      w_len_reg   <= '0;
      w_size_reg  <= '0;
      w_burst_reg <= '0;
      w_err_reg   <= 1'b0;
    end
    else
      case (ws_reg)
        W_IDLE:
          if (awvalid && awready)
          begin
            w_id_reg    <= awid;
            w_addr_reg  <= awaddr;
            w_len_reg   <= awlen;
            w_size_reg  <= awsize;
            w_burst_reg <= awburst;
            w_err_reg   <= burst_err(awburst, awlen, awsize);
            ws_reg      <= W_DATA;
          end
        W_DATA:
          if (w_hs)
          begin
            w_addr_reg <= next_addr(w_addr_reg, w_size_reg, w_len_reg, w_burst_reg);
            if (wlast)
              ws_reg <= W_RESP;
          end
        default:
          if (bready)
            ws_reg <= W_IDLE;
      endcase
  end

  // write channel handshakes and response
  assign awready = (ws_reg == W_IDLE) & ~blocked;
  assign wready  = (ws_reg == W_DATA) & ~blocked;
  assign bvalid  = (ws_reg == W_RESP);
  assign bid     = w_id_reg;
  assign bresp   = w_err_reg ? RESP_SLVERR : RESP_OKAY;

  // axi read channel: one array read per beat, held until taken
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rs_reg      <= R_IDLE;
      r_id_reg    <= '0;
      r_addr_reg  <= '0;
      r_len_reg   <= '0;
      r_cnt_reg   <= '0;
      r_size_reg  <= '0;
      r_burst_reg <= '0;
      r_err_reg   <= 1'b0;
      rdata_reg   <= '0;
    end
    else
      case (rs_reg)
        R_IDLE:
          if (arvalid && arready)
          begin
            r_id_reg    <= arid;
            r_addr_reg  <= araddr;
            r_len_reg   <= arlen;
            r_cnt_reg   <= arlen;
            r_size_reg  <= arsize;
            r_burst_reg <= arburst;
            r_err_reg   <= burst_err(arburst, arlen, arsize);
            rs_reg      <= R_READ;
          end
        R_READ:
          if (axi_rd_go)
          begin
            rdata_reg <= r_err_reg ? '0 : axi_rd_word[DATA_W-1:0];
            rs_reg    <= R_DATA;
          end
        default:
          if (rready)
          begin
            if (r_cnt_reg == '0)
              rs_reg <= R_IDLE;
            else
            begin
              r_cnt_reg  <= r_cnt_reg - 8'h01;
              r_addr_reg <= next_addr(r_addr_reg, r_size_reg, r_len_reg, r_burst_reg);
              rs_reg     <= R_READ;
            end
          end
      endcase
  end

  // read channel handshakes and data
  assign arready = (rs_reg == R_IDLE) & ~blocked;
  assign rvalid  = (rs_reg == R_DATA);
  assign rid     = r_id_reg;
  assign rdata   = rdata_reg;
  assign rresp   = r_err_reg ? RESP_SLVERR : RESP_OKAY;
  assign rlast   = (r_cnt_reg == '0);

  // debug editor read return
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dbg_rvalid <= 1'b0;
      dbg_rdata  <= '0;
    end
    else
    begin
      dbg_rvalid <= dbg_do & ~dbg_write;
      if (dbg_do && !dbg_write)
        dbg_rdata <= mem[dbg_addr];
    end
  end

  // status word
  always_comb
  begin
    status           = '0;
    status[ST_INIT]  = init_busy_reg;
    status[ST_GATE]  = memory_clock_gate;
    status[ST_WBUSY] = (ws_reg != W_IDLE);
    status[ST_RBUSY] = (rs_reg != R_IDLE);
    status[ST_RREQ]  = reset_req;
  end

  // apb slave, zero wait states
  assign apb_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS);
  assign apb_wr  = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;

  // control register
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl_reg <= CTRL_RESET;
    else if (apb_wr && (paddr == REG_CTRL))
      ctrl_reg <= pwdata & CTRL_MASK;
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      prdata <= '0;
    else if (psel && !penable)
    begin
      if (paddr == REG_CTRL)
        prdata <= ctrl_reg;
      else if (paddr == REG_STATUS)
        prdata <= status;
      else
        prdata <= '0;
    end
  end

  // checks
  property p_min_lat;
    @(posedge clk) disable iff (srst)
    mm_readdatavalid |-> $past(mm_rd_do) || $past(mm_rd_do, 2) || $past(mm_rd_do, 3);
  endproperty
  a_min_lat: assert property (p_min_lat) else $error("read data without a read");

  property p_l1_lat;
    @(posedge clk) disable iff (srst)
    (mm_rd_do && ctrl_l1 && !ctrl_l2 && !apb_wr) ##1 !apb_wr |=> mm_readdatavalid;
  endproperty
  a_l1_lat: assert property (p_l1_lat) else $error("l1 latency not two");

  property p_l2_lat;
    @(posedge clk) disable iff (srst)
    (mm_rd_do && ctrl_l1 && ctrl_l2 && !apb_wr) ##1 !apb_wr [*2] |=> mm_readdatavalid;
  endproperty
  a_l2_lat: assert property (p_l2_lat) else $error("l1 plus l2 latency not three");

  property p_b2b;
    @(posedge clk) disable iff (srst)
    (mm_rd_do && !ctrl_l1 && !ctrl_l2 && !apb_wr) ##1 (mm_rd_do && !apb_wr)
      |-> mm_readdatavalid [*2];
  endproperty
  a_b2b: assert property (p_b2b) else $error("back to back reads stalled");

  property p_prior;
    @(posedge clk) disable iff (srst)
    mm_rd_do && axi_wr_do && (axi_wa == mm_address) && (coll == collision_prior_value)
      |=> rd_pipe_reg[0] == $past(axi_old);
  endproperty
  a_prior: assert property (p_prior) else $error("collision did not keep prior word");

  property p_protect;
    @(posedge clk) disable iff (srst)
    reset_req |-> !memory_clock_gate && mm_waitrequest && !awready && !arready;
  endproperty
  a_protect: assert property (p_protect) else $error("memory clock on during reset req");

  property p_idle_gate;
    @(posedge clk) disable iff (srst)
    ctrl_gate && !activity |-> !memory_clock_gate;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle memory clock enabled");

  property p_rom;
    @(posedge clk) disable iff (srst)
    ctrl_rom && w_hs |=> mem[$past(axi_wa)] == $past(axi_old) || $past(mm_wr_do || dbg_do);
  endproperty
  a_rom: assert property (p_rom) else $error("rom write changed contents");

  property p_wrap_err;
    @(posedge clk) disable iff (srst)
    awvalid && awready && (awburst == BURST_WRAP) && (awlen == 8'h02) |=> w_err_reg;
  endproperty
  a_wrap_err: assert property (p_wrap_err) else $error("illegal wrap length taken");

  property p_bresp_after_last;
    @(posedge clk) disable iff (srst)
    $rose(bvalid) |-> $past(w_hs && wlast);
  endproperty
  a_bresp_after_last: assert property (p_bresp_after_last) else $error("early response");

  c_l2_read: cover property (@(posedge clk) disable iff (srst)
    mm_rd_do && ctrl_l1 && ctrl_l2 ##3 mm_readdatavalid);
  c_wrap_done: cover property (@(posedge clk) disable iff (srst)
    w_hs && wlast && (w_burst_reg == BURST_WRAP) && !w_err_reg);
  c_collision: cover property (@(posedge clk) disable iff (srst)
    mm_rd_do && axi_wr_do && (axi_wa == mm_address));
endmodule

// >>> testbench.sv
// self-checking bench for the on-chip ram or rom block
`timescale 1ns/1ns
module testbench import ocram_pkg::*;;
  logic clk, srst, mm_read, mm_write, psel, penable, pwrite;
  logic memory_clock_gate, mm_readdatavalid, mm_waitrequest, pready, pslverr, dbg_rvalid;
  logic reset_req = 0, dbg_req = 0, dbg_write = 0;
  logic [WADDR_W-1:0] mm_address, dbg_addr = '0;
  logic [BYTES-1:0] mm_byteenable, wstrb;
  logic [MEM_W-1:0] mm_writedata, mm_readdata, dbg_rdata, dbg_wdata = '0, d, m;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic perr;
  logic [ID_W-1:0] awid, arid, bid, rid;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [7:0] awlen, arlen;
  logic [2:0] awsize, arsize;
  logic [1:0] awburst, arburst, bresp, rresp, r;
  logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rlast, rvalid, rready;
  logic [DATA_W-1:0] wdata, rdata;
  logic [MEM_W-1:0] exp_q[$], dbg_q[$];
  int lat_q[$];
  time t_q[$];
  int fails = 0, tests_run = 0, lat = 1;
  ocram_top u_ocram_top (.*);
  ocram_axi_host u_ocram_axi_host (.*);
  // clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // apb master: setup, access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // memory-mapped request, held until taken; reads note the expectation
  task automatic mm(input logic w, input logic [7:0] a, input logic [39:0] wd,
                    input logic [3:0] be, input logic [39:0] e);
    mm_read <= !w;
    mm_write <= w;
    mm_address <= a;
    mm_writedata <= wd;
    mm_byteenable <= be;
    do @(posedge clk); while (mm_waitrequest !== 1'b0);
    if (!w)
    begin
      exp_q.push_back(e);
      lat_q.push_back(lat);
      t_q.push_back($time);
    end
  endtask
  task automatic idle;
    mm_read <= 0;
    mm_write <= 0;
    mm_writedata <= ~mm_writedata;
    repeat (4) @(posedge clk);
  endtask
  // read monitor: oldest note against each valid beat
  always @(posedge clk)
    if (mm_readdatavalid === 1'b1)
    begin
      if (exp_q.size() == 0) chk("spurious", 0, 1);
      else
      begin
        chk("readdata", exp_q.pop_front(), mm_readdata);
        chk("latency", 40'(lat_q.pop_front()), 40'(($time - t_q.pop_front()) / 10));
      end
    end
  // debug monitor: oldest noted word against each debug read return
  always @(posedge clk)
    if (dbg_rvalid === 1'b1)
    begin
      if (dbg_q.size() == 0) chk("dbg spurious", 0, 1);
      else chk("dbg_rdata", dbg_q.pop_front(), dbg_rdata);
    end
  // main sequence
  initial
  begin
    srst = 1;
    {psel, penable, pwrite, mm_read, mm_write} = '0;
    {paddr, pwdata, mm_address, mm_writedata, mm_byteenable} = '0;
    void'($urandom(32'hea0f));
    repeat (5) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    apb(0, REG_CTRL, 0);
    chk("ctrl", 40'(CTRL_RESET), 40'(q));
    apb(0, 12'h008, 0);
    chk("unmapped", 0, 40'(q));
    chk("pslverr", 1, 40'(perr));
    mm(0, 8'h05, 0, 0, DEFAULT_IMAGE_WORD);
    idle;
    d = 40'({$urandom, $urandom});
    m = {d[39:32], 8'h00, d[23:16], 8'h00, d[7:0]};
    mm(1, 8'h09, d, 4'b0101, 0);
    idle;
    for (int l = 0; l < 4; l++)
    begin
      apb(1, REG_CTRL, 32'h1 | (l << CTRL_L1));
      lat = 1 + l[0] + l[1];
      mm(0, 8'h09, 0, 0, m);
      mm(0, 8'h09, 0, 0, m);
      idle;
    end
    lat = 1;
    apb(1, REG_CTRL, 32'h21);
    mm(1, 8'h09, ~d, 4'hf, 0);
    idle;
    u_ocram_axi_host.write(32'h44, d[31:0], r);
    chk("rom bresp", 40'(RESP_OKAY), 40'(r));
    apb(1, REG_CTRL, 32'h1);
    mm(0, 8'h09, 0, 0, m);
    mm(0, 8'h11, 0, 0, 0);
    idle;
    d = 40'($urandom);
    u_ocram_axi_host.write(32'h40, d[31:0], r);
    chk("bresp", 40'(RESP_OKAY), 40'(r));
    mm(0, 8'h10, 0, 0, {8'h00, d[31:0]});
    idle;
    // axi read back, then an axi beat and an agent read on one word in one cycle
    u_ocram_axi_host.read(32'h40, q, r);
    chk("rdata", 40'(d[31:0]), 40'(q));
    chk("rresp", 40'(RESP_OKAY), 40'(r));
    fork
      u_ocram_axi_host.write(32'h48, ~d[31:0], r);
      begin
        @(posedge clk);
        mm(0, 8'h12, 0, 0, DEFAULT_IMAGE_WORD);
        mm_read <= 0;
      end
    join
    mm(0, 8'h12, 0, 0, {8'h00, ~d[31:0]});
    idle;
    // protection request stalls and gates, then idle gating
    reset_req <= 1;
    apb(0, REG_STATUS, 0);
    chk("status", 40'(1 << ST_RREQ), 40'(q));
    chk("protect gate", 0, 40'(memory_clock_gate));
    reset_req <= 0;
    apb(1, REG_CTRL, 32'h11);
    chk("idle gate", 0, 40'(memory_clock_gate));
    mm(0, 8'h09, 0, 0, m);
    chk("busy gate", 1, 40'(memory_clock_gate));
    idle;
    // debug editor write, debug read, then a read through the agent
    d = 40'({$urandom, $urandom});
    dbg_req <= 1;
    dbg_write <= 1;
    dbg_addr <= 8'h20;
    dbg_wdata <= d;
    @(posedge clk);
    dbg_write <= 0;
    dbg_q.push_back(d);
    @(posedge clk);
    dbg_req <= 0;
    mm(0, 8'h20, 0, 0, d);
    idle;
    results;
  end
  // watchdog
  initial
  begin
    #100000;
    fails++;
    results;
  end
endmodule
